// File: hdl/hvfc_pkg.sv
/*
 * Shared constants and types for the vicinity-card frame codec.
 * Assumes all link timing is counted in carrier cycles.
 */
package hvfc_pkg;

    // Carrier and request-side times, figures as printed
    localparam longint CAR_HZ      = 64'd13560000;
    localparam longint T_SYM4_NS   = 64'd75520;
    localparam longint T_SYM256_NS = 64'd4833000;
    localparam longint T_EOF_NS    = 64'd37760;
    localparam longint T_SLOT_NS   = 64'd9440;
    localparam longint NS_PER_S    = 64'd1000000000;

    // Nominal figures, rounded to the nearest carrier cycle
    localparam int SYM4_CYC   = int'((T_SYM4_NS * CAR_HZ + NS_PER_S / 2)
                                     / NS_PER_S);
    localparam int SYM256_CYC = int'((T_SYM256_NS * CAR_HZ + NS_PER_S / 2)
                                     / NS_PER_S);
    localparam int EOF_CYC    = int'((T_EOF_NS * CAR_HZ + NS_PER_S / 2)
                                     / NS_PER_S);
    localparam int SLOT_CYC   = int'((T_SLOT_NS * CAR_HZ + NS_PER_S / 2)
                                     / NS_PER_S);
    localparam int T1_CYC     = 4352;

    // Slot index of the second start pause
    localparam logic [8:0] SOF_PER_256 = 9'h004;
    localparam logic [8:0] SOF_PER_4   = 9'h006;

    // Request flag byte bit positions
    localparam int FLG_SUB_BIT  = 0;
    localparam int FLG_RATE_BIT = 1;
    localparam logic [1:0] MIN_BYTES = 2'h3;

    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

    // Low rate stretches every half period by four
    localparam int RATE_LOW_SHIFT = 2;

    typedef struct packed {
        logic [6:0] half;
        logic [6:0] halves;
        logic       tog;
    } hvfc_seg_s;

    localparam hvfc_seg_s SEG_S16 = '{half: 7'h10, halves: 7'h10, tog: 1'b1};
    localparam hvfc_seg_s SEG_MID = '{half: 7'h10, halves: 7'h30, tog: 1'b1};
    localparam hvfc_seg_s SEG_G1  = '{half: 7'h10, halves: 7'h10, tog: 1'b0};
    localparam hvfc_seg_s SEG_G2  = '{half: 7'h0e, halves: 7'h12, tog: 1'b1};
    localparam hvfc_seg_s SEG_L1  = '{half: 7'h10, halves: 7'h30, tog: 1'b0};
    localparam hvfc_seg_s SEG_L2  = '{half: 7'h0e, halves: 7'h36, tog: 1'b1};

    typedef struct packed {
        logic       vld;
        logic       sof;
        logic       mode256;
        logic       end_ok;
        logic       err;
        logic [7:0] data;
    } hvfc_rx_evt_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } hvfc_tx_byte_s;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_SOF  = 2'h1,
        RX_DATA = 2'h3,
        RX_EOF  = 2'h2
    } hvfc_rx_st_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h0,
        TX_WAIT = 4'h1,
        TX_HEAD = 4'h3,
        TX_SOF1 = 4'h2,
        TX_DATA = 4'h6,
        TX_CRC1 = 4'h7,
        TX_CRC2 = 4'h5,
        TX_EOF0 = 4'h4,
        TX_TAIL = 4'hc
    } hvfc_tx_st_e;

endpackage

// File: hdl/hvfc_crc16.sv
`timescale 1ns/1ps
/*
 * Bytewise reflected CRC-16 accumulator.
 * Assumes bytes arrive least significant bit first, one per strobe.
 */
module hvfc_crc16 (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_clear,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_byte,
    output logic      [15:0] o_crc
);
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = o_crc;
        for (int i = 0; i < 8; i++) begin
            if (crc_nxt[0] ^ i_byte[i]) begin
                crc_nxt = (crc_nxt >> 1) ^ hvfc_pkg::CRC_POLY;
            end else begin
                crc_nxt = crc_nxt >> 1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || i_clear) begin
            o_crc <= hvfc_pkg::CRC_INIT;
        end else if (i_valid) begin
            o_crc <= crc_nxt;
        end
    end
endmodule

// File: hdl/hvfc_codec.sv
`timescale 1ns/1ps
/*
 * Request decoder and response encoder for the vicinity air interface.
 * Assumes a carrier square wave and a pause-detect level from the
 * analogue front end, both asynchronous to i_clk_sys.
 */
// Overview of operation
// - Answer only after a good request; never while a request arrives.
// - Both directions frame content with start and end delimiters.
// - Last two bytes hold inverted CRC-16 over all earlier bytes.
// - CRC goes least significant bit first; receiver assembles alike.
// - All symbol timing counts carrier cycles.
// - 256-position byte symbol; pause slot gives the byte value.
// - 4-position symbol carries two bits by pause position.
// - 4-position bytes go as four pairs, low pair first.
// - Second start pause selects 256- or 4-position decoding.
// - Request end delimiter holds one pause, same in both modes.
// - Response uses one or two subcarriers per request flag.
// - Response bit rate follows the second request flag.
// - Response bytes go least significant bit first.
// - One-carrier zero: eight bursts of 16, then 256 quiet.
// - One-carrier one: 256 quiet, then eight bursts of 16.
// - One-carrier start: 768 quiet, 24 bursts, then a one.
// - One-carrier end: a zero, 24 bursts, then 768 quiet.
// - Low rate stretches every response symbol cycle count by four.
// - Two-carrier zero: eight periods of 16, nine of 14.
// - Two-carrier one: nine periods of 14, eight of 16.
// - Two-carrier start: 27 of 14, 24 of 16, then a one.
// - Two-carrier end: a zero, 24 of 16, then 27 of 14.
// - Response start follows request end by 4352 carrier cycles.
module hvfc_codec #(
    parameter int P_T1_CYC     = hvfc_pkg::T1_CYC,
    parameter int P_SYM256_CYC = hvfc_pkg::SYM256_CYC
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_carrier,
    input  wire logic                    i_pause,
    input  wire hvfc_pkg::hvfc_tx_byte_s i_tx,
    output logic                         o_tx_take,
    output logic                         o_tx_busy,
    output logic                         o_mod,
    output hvfc_pkg::hvfc_rx_evt_s       o_rx
);
    localparam logic [15:0] SYM4_LAST   = 16'(hvfc_pkg::SYM4_CYC - 1);
    localparam logic [15:0] SYM256_LAST = 16'(P_SYM256_CYC - 1);
    localparam logic [15:0] EOF_LAST    = 16'(hvfc_pkg::EOF_CYC - 1);
    localparam logic [15:0] T1_LAST     = 16'(P_T1_CYC - 1);
    // 512 half slots per byte symbol; rounds the odd nominal length
    localparam int          SLOT256_CYC = (P_SYM256_CYC + 256) / 512;

    logic car_s1_r;
    logic car_s2_r;
    logic car_s3_r;
    logic pau_s1_r;
    logic pau_s2_r;
    logic pau_s3_r;

    // Carrier edges and pause starts seen only after two flops
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            {car_s1_r, car_s2_r, car_s3_r} <= 3'h0;
            {pau_s1_r, pau_s2_r, pau_s3_r} <= 3'h0;
        end else begin
            {car_s1_r, car_s2_r, car_s3_r} <= {i_carrier, car_s1_r, car_s2_r};
            {pau_s1_r, pau_s2_r, pau_s3_r} <= {i_pause, pau_s1_r, pau_s2_r};
        end
    end

    wire car_edge = car_s2_r & ~car_s3_r;
    wire pause_st = pau_s2_r & ~pau_s3_r;

    hvfc_pkg::hvfc_rx_st_e  rx_st_r;
    hvfc_pkg::hvfc_rx_st_e  rx_st_nxt;
    hvfc_pkg::hvfc_tx_st_e  tx_st_r;
    hvfc_pkg::hvfc_tx_st_e  tx_st_nxt;
    hvfc_pkg::hvfc_rx_evt_s evt_nxt;
    hvfc_pkg::hvfc_seg_s    seg;

    logic [15:0] rcnt_r;
    logic [15:0] rcnt_nxt;
    logic        got_r;
    logic        got_nxt;
    logic [1:0]  pair_r;
    logic [1:0]  pair_nxt;
    logic [7:0]  rbyte_r;
    logic [7:0]  rbyte_nxt;
    logic        mode256_r;
    logic        mode256_nxt;
    logic [1:0]  nbytes_r;
    logic [1:0]  nbytes_nxt;
    logic [1:0]  flags_r;
    logic [1:0]  flags_nxt;
    logic        err_c;
    logic        emit_c;
    logic [7:0]  byte_c;
    logic        rx_clr_c;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;

    logic [15:0] tcnt_r;
    logic [15:0] tcnt_nxt;
    logic        seg_idx_r;
    logic        seg_idx_nxt;
    logic [6:0]  cyc_r;
    logic [6:0]  cyc_nxt;
    logic [6:0]  half_r;
    logic [6:0]  half_nxt;
    logic [7:0]  sh_r;
    logic [7:0]  sh_nxt;
    logic [2:0]  bitn_r;
    logic [2:0]  bitn_nxt;
    logic        last_r;
    logic        last_nxt;
    logic        sub2_r;
    logic        sub2_nxt;
    logic        rlow_r;
    logic        rlow_nxt;
    logic        take_c;
    logic        tx_clr_c;

    // Byte slots scale with a shortened 256-position symbol
    wire [8:0]  per       = (mode256_r && rx_st_r == hvfc_pkg::RX_DATA) ?
                            9'(rcnt_r / SLOT256_CYC) :
                            9'(rcnt_r / hvfc_pkg::SLOT_CYC);
    wire [15:0] sym_last  = mode256_r ? SYM256_LAST : SYM4_LAST;
    wire        crc_ok    = rx_crc == hvfc_pkg::CRC_RESIDUE;
    wire        tx_active = tx_st_r != hvfc_pkg::TX_IDLE &&
                            tx_st_r != hvfc_pkg::TX_WAIT;
    wire [7:0]  pair_byte = {per[2:1], rbyte_r[7:2]};

    // Receive side: delimiter, pulse position and CRC checks
    always_comb begin
        rx_st_nxt   = rx_st_r;
        rcnt_nxt    = rcnt_r;
        got_nxt     = got_r;
        pair_nxt    = pair_r;
        rbyte_nxt   = rbyte_r;
        mode256_nxt = mode256_r;
        nbytes_nxt  = nbytes_r;
        flags_nxt   = flags_r;
        evt_nxt     = '0;
        err_c       = 1'b0;
        emit_c      = 1'b0;
        byte_c      = 8'h00;
        rx_clr_c    = 1'b0;
        if (car_edge && rx_st_r != hvfc_pkg::RX_IDLE) begin
            rcnt_nxt = rcnt_r + 16'h0001;
        end
        case (rx_st_r)
            hvfc_pkg::RX_IDLE: begin
                if (pause_st && !tx_active) begin
                    rx_st_nxt  = hvfc_pkg::RX_SOF;
                    rcnt_nxt   = 16'h0000;
                    got_nxt    = 1'b0;
                    nbytes_nxt = 2'h0;
                    rx_clr_c   = 1'b1;
                end
            end
            hvfc_pkg::RX_SOF: begin
                if (car_edge && rcnt_r == SYM4_LAST) begin
                    if (got_r) begin
                        rx_st_nxt       = hvfc_pkg::RX_DATA;
                        rcnt_nxt        = 16'h0000;
                        got_nxt         = 1'b0;
                        pair_nxt        = 2'h0;
                        evt_nxt.sof     = 1'b1;
                        evt_nxt.mode256 = mode256_r;
                    end else begin
                        err_c = 1'b1;
                    end
                end
                if (pause_st) begin
                    if (!got_r && per == hvfc_pkg::SOF_PER_256) begin
                        got_nxt     = 1'b1;
                        mode256_nxt = 1'b1;
                    end else if (!got_r && per == hvfc_pkg::SOF_PER_4) begin
                        got_nxt     = 1'b1;
                        mode256_nxt = 1'b0;
                    end else begin
                        err_c = 1'b1;
                    end
                end
            end
            hvfc_pkg::RX_DATA: begin
                if (car_edge && rcnt_r == sym_last) begin
                    rcnt_nxt = 16'h0000;
                    got_nxt  = 1'b0;
                    err_c    = !got_r;
                end
                if (pause_st) begin
                    if (per == 9'h000 && !got_r && pair_r == 2'h0) begin
                        rx_st_nxt = hvfc_pkg::RX_EOF;
                    end else if (got_r || !per[0]) begin
                        err_c = 1'b1;
                    end else if (mode256_r) begin
                        got_nxt = 1'b1;
                        emit_c  = 1'b1;
                        byte_c  = per[8:1];
                    end else begin
                        got_nxt   = 1'b1;
                        pair_nxt  = pair_r + 2'h1;
                        rbyte_nxt = pair_byte;
                        emit_c    = pair_r == 2'h3;
                        byte_c    = pair_byte;
                    end
                end
            end
            hvfc_pkg::RX_EOF: begin
                if (pause_st) begin
                    err_c = 1'b1;
                end else if (car_edge && rcnt_r == EOF_LAST) begin
                    rx_st_nxt = hvfc_pkg::RX_IDLE;
                    if (crc_ok && nbytes_r == hvfc_pkg::MIN_BYTES) begin
                        evt_nxt.end_ok = 1'b1;
                    end else begin
                        err_c = 1'b1;
                    end
                end
            end
            default: begin
                rx_st_nxt = hvfc_pkg::RX_IDLE;
            end
        endcase
        if (emit_c) begin
            evt_nxt.vld  = 1'b1;
            evt_nxt.data = byte_c;
            if (nbytes_r == 2'h0) begin
                flags_nxt = {byte_c[hvfc_pkg::FLG_RATE_BIT],
                             byte_c[hvfc_pkg::FLG_SUB_BIT]};
            end
            if (nbytes_r != hvfc_pkg::MIN_BYTES) begin
                nbytes_nxt = nbytes_r + 2'h1;
            end
        end
        if (err_c) begin
            rx_st_nxt   = hvfc_pkg::RX_IDLE;
            evt_nxt.err = 1'b1;
        end
    end

    hvfc_crc16 u_rx_crc (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_clear   (rx_clr_c),
        .i_valid   (emit_c),
        .i_byte    (byte_c),
        .o_crc     (rx_crc)
    );

    // Segment pattern for the current symbol half
    wire tx_bit = tx_st_r == hvfc_pkg::TX_SOF1 ? 1'b1 :
                  tx_st_r == hvfc_pkg::TX_EOF0 ? 1'b0 : sh_r[0];
    wire hvfc_pkg::hvfc_seg_s seg_long =
        sub2_r ? hvfc_pkg::SEG_L2 : hvfc_pkg::SEG_L1;
    wire hvfc_pkg::hvfc_seg_s seg_gap =
        sub2_r ? hvfc_pkg::SEG_G2 : hvfc_pkg::SEG_G1;

    always_comb begin
        if (tx_st_r == hvfc_pkg::TX_HEAD) begin
            seg = seg_idx_r ? hvfc_pkg::SEG_MID : seg_long;
        end else if (tx_st_r == hvfc_pkg::TX_TAIL) begin
            seg = seg_idx_r ? seg_long : hvfc_pkg::SEG_MID;
        end else if (tx_bit ^ seg_idx_r) begin
            seg = seg_gap;
        end else begin
            seg = hvfc_pkg::SEG_S16;
        end
    end

    wire [6:0] half_len  = rlow_r ? 7'(seg.half << hvfc_pkg::RATE_LOW_SHIFT)
                                  : seg.half;
    wire       last_cyc  = cyc_r == half_len - 7'h01;
    wire       last_half = half_r == seg.halves - 7'h01;
    wire       sym_done  = car_edge & tx_active & last_cyc & last_half &
                           seg_idx_r;

    // Transmit side: reply timing, symbol order and CRC append
    always_comb begin
        tx_st_nxt   = tx_st_r;
        tcnt_nxt    = tcnt_r;
        seg_idx_nxt = seg_idx_r;
        cyc_nxt     = cyc_r;
        half_nxt    = half_r;
        sh_nxt      = sh_r;
        bitn_nxt    = bitn_r;
        last_nxt    = last_r;
        sub2_nxt    = sub2_r;
        rlow_nxt    = rlow_r;
        take_c      = 1'b0;
        tx_clr_c    = 1'b0;
        if (!tx_active) begin
            {seg_idx_nxt, cyc_nxt, half_nxt} = 15'h0000;
        end else if (car_edge) begin
            if (!last_cyc) begin
                cyc_nxt = cyc_r + 7'h01;
            end else if (!last_half) begin
                cyc_nxt  = 7'h00;
                half_nxt = half_r + 7'h01;
            end else begin
                cyc_nxt     = 7'h00;
                half_nxt    = 7'h00;
                seg_idx_nxt = ~seg_idx_r;
            end
        end
        case (tx_st_r)
            hvfc_pkg::TX_IDLE: begin
                if (evt_nxt.end_ok) begin
                    tx_st_nxt = hvfc_pkg::TX_WAIT;
                    tcnt_nxt  = 16'h0000;
                    tx_clr_c  = 1'b1;
                    sub2_nxt  = flags_r[0];
                    rlow_nxt  = !flags_r[1];
                end
            end
            hvfc_pkg::TX_WAIT: begin
                if (pause_st) begin
                    tx_st_nxt = hvfc_pkg::TX_IDLE;
                end else if (car_edge && tcnt_r == T1_LAST) begin
                    if (i_tx.valid) begin
                        tx_st_nxt = hvfc_pkg::TX_HEAD;
                        take_c    = 1'b1;
                    end else begin
                        tx_st_nxt = hvfc_pkg::TX_IDLE;
                    end
                end else if (car_edge) begin
                    tcnt_nxt = tcnt_r + 16'h0001;
                end
            end
            hvfc_pkg::TX_HEAD: begin
                if (sym_done) tx_st_nxt = hvfc_pkg::TX_SOF1;
            end
            hvfc_pkg::TX_SOF1: begin
                if (sym_done) tx_st_nxt = hvfc_pkg::TX_DATA;
            end
            hvfc_pkg::TX_DATA, hvfc_pkg::TX_CRC1, hvfc_pkg::TX_CRC2: begin
                if (sym_done) begin
                    sh_nxt   = sh_r >> 1;
                    bitn_nxt = bitn_r + 3'h1;
                    if (bitn_r == 3'h7) begin
                        if (tx_st_r == hvfc_pkg::TX_CRC2) begin
                            tx_st_nxt = hvfc_pkg::TX_EOF0;
                        end else if (tx_st_r == hvfc_pkg::TX_CRC1) begin
                            tx_st_nxt = hvfc_pkg::TX_CRC2;
                            sh_nxt    = ~tx_crc[15:8];
                        end else if (!last_r && i_tx.valid) begin
                            take_c = 1'b1;
                        end else begin
                            tx_st_nxt = hvfc_pkg::TX_CRC1;
                            sh_nxt    = ~tx_crc[7:0];
                        end
                    end
                end
            end
            hvfc_pkg::TX_EOF0: begin
                if (sym_done) tx_st_nxt = hvfc_pkg::TX_TAIL;
            end
            hvfc_pkg::TX_TAIL: begin
                if (sym_done) tx_st_nxt = hvfc_pkg::TX_IDLE;
            end
            default: begin
                tx_st_nxt = hvfc_pkg::TX_IDLE;
            end
        endcase
        if (take_c) begin
            sh_nxt   = i_tx.data;
            last_nxt = i_tx.last;
            bitn_nxt = 3'h0;
        end
    end

    hvfc_crc16 u_tx_crc (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_clear   (tx_clr_c),
        .i_valid   (take_c),
        .i_byte    (i_tx.data),
        .o_crc     (tx_crc)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rx_st_r   <= hvfc_pkg::RX_IDLE;
            rcnt_r    <= 16'h0000;
            got_r     <= 1'b0;
            pair_r    <= 2'h0;
            rbyte_r   <= 8'h00;
            mode256_r <= 1'b0;
            nbytes_r  <= 2'h0;
            flags_r   <= 2'h0;
            o_rx      <= '0;
        end else begin
            rx_st_r   <= rx_st_nxt;
            rcnt_r    <= rcnt_nxt;
            got_r     <= got_nxt;
            pair_r    <= pair_nxt;
            rbyte_r   <= rbyte_nxt;
            mode256_r <= mode256_nxt;
            nbytes_r  <= nbytes_nxt;
            flags_r   <= flags_nxt;
            o_rx      <= evt_nxt;
        end
    end

    // Modulation level comes from even halves of toggling segments
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tx_st_r   <= hvfc_pkg::TX_IDLE;
            tcnt_r    <= 16'h0000;
            seg_idx_r <= 1'b0;
            cyc_r     <= 7'h00;
            half_r    <= 7'h00;
            sh_r      <= 8'h00;
            bitn_r    <= 3'h0;
            last_r    <= 1'b0;
            sub2_r    <= 1'b0;
            rlow_r    <= 1'b0;
            o_tx_take <= 1'b0;
            o_tx_busy <= 1'b0;
            o_mod     <= 1'b0;
        end else begin
            tx_st_r   <= tx_st_nxt;
            tcnt_r    <= tcnt_nxt;
            seg_idx_r <= seg_idx_nxt;
            cyc_r     <= cyc_nxt;
            half_r    <= half_nxt;
            sh_r      <= sh_nxt;
            bitn_r    <= bitn_nxt;
            last_r    <= last_nxt;
            sub2_r    <= sub2_nxt;
            rlow_r    <= rlow_nxt;
            o_tx_take <= take_c;
            o_tx_busy <= tx_st_r != hvfc_pkg::TX_IDLE;
            o_mod     <= tx_active & seg.tog & ~half_r[0];
        end
    end
endmodule

// File: sim/hvfc_codec_asserts.sv
`timescale 1ns/1ps
/* Port checker for hvfc_codec, bound below.
   Assumes the carrier is much slower than i_clk_sys. */
module hvfc_codec_asserts #(
    parameter int P_T1_CYC     = hvfc_pkg::T1_CYC,
    parameter int P_SYM256_CYC = hvfc_pkg::SYM256_CYC
) (
    input wire logic                    i_clk_sys,
    input wire logic                    i_rst_b,
    input wire logic                    i_carrier,
    input wire logic                    i_pause,
    input wire hvfc_pkg::hvfc_tx_byte_s i_tx,
    input wire logic                    o_tx_take,
    input wire logic                    o_tx_busy,
    input wire logic                    o_mod,
    input wire hvfc_pkg::hvfc_rx_evt_s  o_rx
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    a_idle_no_mod: assert property (!o_tx_busy &&
        !$past(o_tx_busy) |-> !o_mod) else $error("mod while idle");
    a_rx_mute_tx: assert property (o_mod |->
        !o_rx.vld && !o_rx.sof) else $error("rx event while sending");
    a_mode_only_sof: assert property (o_rx.mode256 |->
        o_rx.sof) else $error("mode flag without start");
    a_end_err_excl: assert property (!(o_rx.end_ok &&
        o_rx.err)) else $error("end and error together");
    a_end_arms_reply: assert property (o_rx.end_ok |=>
        o_tx_busy) else $error("no busy after good end");
    a_wait_quiet: assert property ($rose(o_tx_busy) |=>
        !o_mod [*8]) else $error("mod during reply wait");
    a_burst_min: assert property ($rose(o_mod) |=>
        o_mod [*8]) else $error("burst too short");
    a_take_pulse: assert property (o_tx_take |-> o_tx_busy
        ##1 !o_tx_take) else $error("take pulse bad");
endmodule

bind hvfc_codec hvfc_codec_asserts #(.P_T1_CYC(P_T1_CYC),
    .P_SYM256_CYC(P_SYM256_CYC)) i_chk (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_carrier(i_carrier), .i_pause(i_pause),
    .i_tx(i_tx), .o_tx_take(o_tx_take), .o_tx_busy(o_tx_busy),
    .o_mod(o_mod), .o_rx(o_rx));

// File: sim/hvfc_reader_model.sv
`timescale 1ns/1ps
/* Reader stand-in: field carrier and pause line.
   Assumes the bench places pauses in rising frame order. */
module hvfc_reader_model (
    input  wire logic i_field,
    output logic      o_carrier,
    output logic      o_pause
);
    logic ph = 1'b0;
    int   pos;
    // Field runs free once on: it powers the tag
    always #200 ph = ~ph;
    assign o_carrier = i_field & ph;
    initial o_pause = 1'b0;
    // Only the reader opens an exchange; one pause per call
    task automatic pulse_at(input int t);
        repeat (t - pos) @(posedge o_carrier);
        o_pause <= 1'b1;
        repeat (2) @(posedge o_carrier);
        o_pause <= 1'b0;
        pos = t + 2;
    endtask
endmodule

// File: sim/tb_hvfc_codec.sv
`timescale 1ns/1ps
/* Self-checking bench for hvfc_codec.
   Assumes the reader model supplies carrier and pauses. */
module tb_hvfc_codec;
    logic                    i_clk_sys = 1'b0;
    logic                    i_rst_b = 1'b0;
    logic                    field = 1'b0;
    logic                    car;
    logic                    pause;
    hvfc_pkg::hvfc_tx_byte_s tx = '0;
    logic                    take;
    logic                    busy;
    logic                    mod;
    hvfc_pkg::hvfc_rx_evt_s  rx;
    logic                    m256 = 1'b0;
    logic [7:0]              rxq[$];
    int n_mismatch, check_count, n_sof, n_end, n_err, ncar, c_end, cyc;

    hvfc_codec #(.P_T1_CYC(64), .P_SYM256_CYC(2048)) i_dut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_carrier(car),
        .i_pause(pause), .i_tx(tx), .o_tx_take(take), .o_tx_busy(busy),
        .o_mod(mod), .o_rx(rx));
    hvfc_reader_model i_rdr (.i_field(field), .o_carrier(car),
        .o_pause(pause));

    always #25 i_clk_sys = ~i_clk_sys;
    always @(posedge car) ncar++;
    // Events stand one cycle, so catch them here
    always @(posedge i_clk_sys) begin
        if (rx.vld) rxq.push_back(rx.data);
        if (rx.sof) begin
            n_sof++;
            m256 = rx.mode256;
        end
        if (rx.end_ok) begin
            n_end++;
            c_end = ncar;
        end
        if (rx.err) n_err++;
        if (++cyc == 110000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return take;
            1: return mod;
            2: return n_end != 0;
            default: return n_err != 0;
        endcase
    endfunction
    task automatic wait_on(input int sel, input logic v);
        for (int n = 0; n < 20000 && pick(sel) !== v; n++) begin
            @(posedge i_clk_sys);
        end
    endtask
    function automatic logic [15:0] crc_inv(input logic [7:0] b);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'h8408 : 16'h0000);
        end
        return ~c;
    endfunction

    task automatic t_sof_bad;
        i_rdr.pos = 0;
        i_rdr.pulse_at(0);
        i_rdr.pulse_at(704);
        wait_on(3, 1'b1);
        chk("bad_err", n_err, 1);
        chk("bad_sof", n_sof, 0);
        chk("bad_busy", busy, 1'b0);
        // Four-position start, one good pair, then a second pause
        i_rdr.pulse_at(720);
        i_rdr.pulse_at(1552);
        i_rdr.pulse_at(1936);
        chk("q4_sof", n_sof, 1);
        chk("q4_mode", m256, 1'b0);
        chk("q4_pair", n_err, 1);
        i_rdr.pulse_at(2192);
        repeat (4) @(posedge car);
        chk("q4_twice", n_err, 2);
        $display("bad start done");
    endtask

    task automatic t_good;
        logic [15:0] e;
        logic [7:0]  b [3];
        int          q;
        e = crc_inv(8'h02);
        b = '{8'h02, e[7:0], e[15:8]};
        i_rdr.pos = 0;
        i_rdr.pulse_at(0);
        i_rdr.pulse_at(576);
        // Pauses sit late in their slot, clear of symbol edges
        for (int k = 0; k < 3; k++) begin
            i_rdr.pulse_at(1024 + 2048 * k + 8 * b[k] + 7);
        end
        i_rdr.pulse_at(7170);
        @(posedge i_clk_sys);
        tx <= '{valid: 1'b1, last: 1'b0, data: 8'ha5};
        wait_on(2, 1'b1);
        chk("sof", n_sof, 2);
        chk("mode", m256, 1'b1);
        chk("end", n_end, 1);
        chk("count", rxq.size(), 3);
        for (int k = 0; k < 3; k++) chk("byte", rxq[k], b[k]);
        wait_on(0, 1'b1);
        tx <= '{valid: 1'b1, last: 1'b1, data: 8'h3c};
        chk("busy", busy, 1'b1);
        q = ncar - c_end;
        chk("t1", q >= 63 && q <= 66, 1'b1);
        q = ncar;
        wait_on(1, 1'b1);
        q = ncar - q;
        chk("quiet", q >= 767 && q <= 769, 1'b1);
        for (int k = 0; k < 24; k++) begin
            q = ncar;
            wait_on(1, 1'b0);
            chk("on", ncar - q, 16);
            q = ncar;
            wait_on(1, 1'b1);
            chk("off", ncar - q, k == 23 ? 272 : 16);
        end
        i_rst_b <= 1'b0;
        field   <= 1'b0;
        tx      <= '0;
        repeat (4) @(posedge i_clk_sys);
        chk("rst_mod", mod, 1'b0);
        chk("rst_busy", busy, 1'b0);
        $display("good frame done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        field <= 1'b1;
        t_sof_bad();
        t_good();
        print_verdict();
    end
endmodule
